// File: design/ssf_status.sv
/*
  Status flag logic of a serial unit with its holding buffers and an
  APB register port.
  Assumes the shifter datapath sits on clk_sys and gives one-cycle
  event pulses; the bit-rate and shifting logic live outside.
*/
`timescale 1ns/1ns

module ssf_status (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          low_power_entry,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ssf_pkg::SSF_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          tx_load,
  input  wire logic                          tx_last_bit,
  input  wire logic                          rx_done,
  input  wire ssf_pkg::ssf_rx_frame_s        rx_frame,
  output logic      [7:0]                    tx_holding_data,
  output logic                               tx_holding_valid,
  output ssf_pkg::ssf_control_s              serial_control,
  output logic                               mp_bit_to_send,
  output logic                               rx_halt,
  output logic                               tx_halt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]                     status_r;
  logic [ssf_pkg::SSF_NFLAG-1:0]  armed_r;
  ssf_pkg::ssf_control_s          control_r;
  logic [7:0]                     tx_holding_buffer_r;
  logic [7:0]                     rx_buffer_r;
  logic                           pslverr_r;
  logic [31:0]                    prdata_r;

  logic                           tx_holding_empty;
  logic                           rx_buffer_full;
  logic                           overrun_error;
  logic                           framing_error;
  logic                           parity_error;
  logic                           tx_done;
  logic                           mp_bit_received;

  logic                           setup_ph;
  logic                           access_wr;
  logic                           access_rd;
  logic                           wr_status;
  logic                           wr_control;
  logic                           wr_txbuf;
  logic                           rd_status;
  logic                           rd_rxbuf;
  logic                           soft_reset;
  logic                           tx_en;
  logic                           rx_accept;
  logic                           frame_bad;
  logic                           parity_bad;
  logic                           any_err;
  logic [7:0]                     status_nxt;
  logic [ssf_pkg::SSF_NFLAG-1:0]  armed_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ssf_pkg::SSF_ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [ssf_pkg::SSF_ADDR_W-1:0] a);
    mapped = hit(a, ssf_pkg::SSF_OFF_STATUS) || hit(a, ssf_pkg::SSF_OFF_CONTROL) ||
             hit(a, ssf_pkg::SSF_OFF_TXBUF) || hit(a, ssf_pkg::SSF_OFF_RXBUF);
  endfunction

  assign setup_ph   = psel && !penable;
  assign access_wr  = psel && penable && pwrite;
  assign access_rd  = psel && penable && !pwrite;
  assign wr_status  = access_wr && hit(paddr, ssf_pkg::SSF_OFF_STATUS);
  assign wr_control = access_wr && hit(paddr, ssf_pkg::SSF_OFF_CONTROL);
  assign wr_txbuf   = access_wr && hit(paddr, ssf_pkg::SSF_OFF_TXBUF);
  assign rd_status  = access_rd && hit(paddr, ssf_pkg::SSF_OFF_STATUS);
  assign rd_rxbuf   = access_rd && hit(paddr, ssf_pkg::SSF_OFF_RXBUF);

  assign pready  = 1'b1;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // Read data is latched in the setup cycle so it comes from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= !mapped(paddr);
      prdata_r  <= 32'h0000_0000;
      if (hit(paddr, ssf_pkg::SSF_OFF_STATUS)) begin
        prdata_r[7:0] <= status_r;
      end else if (hit(paddr, ssf_pkg::SSF_OFF_CONTROL)) begin
        prdata_r[7:0] <= control_r;
      end else if (hit(paddr, ssf_pkg::SSF_OFF_TXBUF)) begin
        prdata_r[7:0] <= tx_holding_buffer_r;
      end else if (hit(paddr, ssf_pkg::SSF_OFF_RXBUF)) begin
        prdata_r[7:0] <= rx_buffer_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag aliases and receive checks
  // ----------------------------------------------------------------
  assign tx_holding_empty = status_r[ssf_pkg::SSF_B_TX_HOLDING_EMPTY];
  assign rx_buffer_full   = status_r[ssf_pkg::SSF_B_RX_BUFFER_FULL];
  assign overrun_error    = status_r[ssf_pkg::SSF_B_OER];
  assign framing_error    = status_r[ssf_pkg::SSF_B_FER];
  assign parity_error     = status_r[ssf_pkg::SSF_B_PER];
  assign tx_done          = status_r[ssf_pkg::SSF_B_TX_DONE];
  assign mp_bit_received  = status_r[ssf_pkg::SSF_B_MP_BIT_RECEIVED];
  assign soft_reset       = reset || low_power_entry;
  assign tx_en            = control_r.tx_enable_bit;

  // Any error flag stalls the receiver; sync mode stalls both ways
  assign rx_halt    = overrun_error || framing_error || parity_error;
  assign tx_halt    = control_r.sync_mode && rx_halt;
  assign rx_accept  = rx_done && control_r.rx_enable_bit && !rx_halt;
  // Second stop bit never looked at
  assign frame_bad  = !control_r.sync_mode && !rx_frame.stop_first;
  assign parity_bad = !control_r.sync_mode && control_r.parity_en &&
                      ((^{rx_frame.data, rx_frame.parity_bit}) != control_r.parity_odd);
  assign any_err    = frame_bad || parity_bad;

  // ----------------------------------------------------------------
  // Status next value: clears first, hardware sets override them
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    armed_nxt  = armed_r;
    if (rd_status) begin
      armed_nxt = armed_r | prdata_r[7:ssf_pkg::SSF_FLAG_LO];
    end
    if (wr_status) begin
      // Flags clear only on a zero while armed and ignore ones; mp_bit_to_send takes the written bit either way
      for (int i = 0; i < ssf_pkg::SSF_NFLAG; i++) begin
        if (armed_r[i] && !pwdata[ssf_pkg::SSF_FLAG_LO + i]) begin
          status_nxt[ssf_pkg::SSF_FLAG_LO + i] = 1'b0;
        end
      end
      armed_nxt = '0;
      if (armed_r[ssf_pkg::SSF_B_TX_HOLDING_EMPTY - ssf_pkg::SSF_FLAG_LO] &&
          !pwdata[ssf_pkg::SSF_B_TX_HOLDING_EMPTY]) begin
        status_nxt[ssf_pkg::SSF_B_TX_DONE] = 1'b0;
      end
      status_nxt[ssf_pkg::SSF_B_MP_BIT_TO_SEND] = pwdata[ssf_pkg::SSF_B_MP_BIT_TO_SEND];
    end
    if (wr_txbuf && tx_en) begin
      status_nxt[ssf_pkg::SSF_B_TX_HOLDING_EMPTY] = 1'b0;
      status_nxt[ssf_pkg::SSF_B_TX_DONE] = 1'b0;
    end
    if (rd_rxbuf) begin
      status_nxt[ssf_pkg::SSF_B_RX_BUFFER_FULL] = 1'b0;
    end
    if (tx_load) begin
      status_nxt[ssf_pkg::SSF_B_TX_HOLDING_EMPTY] = 1'b1;
    end
    if (tx_last_bit && tx_holding_empty) begin
      status_nxt[ssf_pkg::SSF_B_TX_DONE] = 1'b1;
    end
    if (!tx_en) begin
      status_nxt[ssf_pkg::SSF_B_TX_HOLDING_EMPTY] = 1'b1;
      status_nxt[ssf_pkg::SSF_B_TX_DONE] = 1'b1;
    end
    if (rx_accept) begin
      if (rx_buffer_full) begin
        status_nxt[ssf_pkg::SSF_B_OER] = 1'b1;
      end else begin
        status_nxt[ssf_pkg::SSF_B_FER] = frame_bad ? 1'b1 : status_nxt[ssf_pkg::SSF_B_FER];
        status_nxt[ssf_pkg::SSF_B_PER] = parity_bad ? 1'b1 : status_nxt[ssf_pkg::SSF_B_PER];
        if (!any_err) begin
          status_nxt[ssf_pkg::SSF_B_RX_BUFFER_FULL] = 1'b1;
        end
        if (!control_r.sync_mode && control_r.mp_format) begin
          status_nxt[ssf_pkg::SSF_B_MP_BIT_RECEIVED] = rx_frame.mp_bit;
        end
      end
    end
  end

  // Receive disable is not a clear source for any flag
  always_ff @(posedge clk_sys) begin
    if (soft_reset) begin
      status_r <= ssf_pkg::SSF_STATUS_RST;
      armed_r  <= '0;
    end else begin
      status_r <= status_nxt;
      armed_r  <= armed_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control and buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_r <= ssf_pkg::SSF_CONTROL_RST;
    end else if (wr_control) begin
      control_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_holding_buffer_r <= ssf_pkg::SSF_BUF_RST;
    end else if (wr_txbuf) begin
      tx_holding_buffer_r <= pwdata[7:0];
    end
  end

  // Overrun leaves the earlier character in place
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_buffer_r <= ssf_pkg::SSF_BUF_RST;
    end else if (rx_accept && !rx_buffer_full) begin
      rx_buffer_r <= rx_frame.data;
    end
  end

  assign tx_holding_data  = tx_holding_buffer_r;
  assign tx_holding_valid = tx_en && !tx_holding_empty && !tx_halt;
  assign serial_control   = control_r;
  assign mp_bit_to_send   = status_r[ssf_pkg::SSF_B_MP_BIT_TO_SEND];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_value: assert property (@(posedge clk_sys)
    soft_reset |=> status_r == ssf_pkg::SSF_STATUS_RST)
    else $error("status not at reset value");

  chk_tx_load_sets: assert property (@(posedge clk_sys) disable iff (reset)
    tx_load && !low_power_entry |=> tx_holding_empty)
    else $error("transmit-empty not set on load");

  chk_tx_off_flags: assert property (@(posedge clk_sys) disable iff (reset)
    !tx_en && !low_power_entry |=> tx_holding_empty && tx_done)
    else $error("flags not set with transmit off");

  chk_txbuf_clear: assert property (@(posedge clk_sys) disable iff (reset)
    wr_txbuf && tx_en && !tx_load && !low_power_entry |=> !tx_holding_empty)
    else $error("buffer write did not clear transmit-empty");

  chk_rx_clean: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && !any_err && !low_power_entry
    |=> rx_buffer_full && rx_buffer_r == $past(rx_frame.data))
    else $error("clean reception not stored");

  chk_overrun_keep: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && rx_buffer_full && !low_power_entry
    |=> overrun_error && $stable(rx_buffer_r) ##1 rx_halt)
    else $error("overrun not flagged or buffer changed");

  chk_framing_nofull: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && frame_bad && !low_power_entry
    |=> framing_error && !rx_buffer_full)
    else $error("framing error handling wrong");

  chk_no_soft_set: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(overrun_error) |-> $past(rx_accept))
    else $error("overrun rose without reception");

  chk_unarmed_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_status && !armed_r[ssf_pkg::SSF_B_FER - ssf_pkg::SSF_FLAG_LO] &&
    framing_error && !low_power_entry |=> framing_error)
    else $error("unarmed write cleared framing error");

  chk_rxbuf_read: assert property (@(posedge clk_sys) disable iff (reset)
    rd_rxbuf && !rx_accept |=> !rx_buffer_full)
    else $error("buffer read did not clear receive-full");

  // ----------------------------------------------------------------
  // Checks: software access, receive sources and transmit end
  // ----------------------------------------------------------------
  // Antecedents leave out same-cycle hardware sets, which win by design
  chk_end_on_last: assert property (@(posedge clk_sys) disable iff (reset)
    tx_last_bit && tx_holding_empty && !low_power_entry |=> tx_done)
    else $error("transmit-end not set on last bit");

  chk_mp_capture: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && !control_r.sync_mode && control_r.mp_format &&
    !low_power_entry |=> mp_bit_received == $past(rx_frame.mp_bit))
    else $error("received mp bit not captured");

  chk_mp_readonly: assert property (@(posedge clk_sys) disable iff (reset)
    wr_status && !rx_done && !low_power_entry |=> $stable(mp_bit_received))
    else $error("status write changed received mp bit");

  chk_no_soft_rise: assert property (@(posedge clk_sys) disable iff (reset)
    wr_status && !rx_done && !low_power_entry
    |=> !$rose(rx_buffer_full) && !$rose(overrun_error) &&
        !$rose(framing_error) && !$rose(parity_error))
    else $error("status write set a flag");

  chk_rx_off_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    rx_done && !control_r.rx_enable_bit && !rd_rxbuf && !wr_status && !low_power_entry
    |=> $stable(rx_buffer_r) && $stable(rx_buffer_full))
    else $error("reception taken while disabled");

  chk_ctrl_keeps_err: assert property (@(posedge clk_sys) disable iff (reset)
    wr_control && !rx_done && !low_power_entry
    |=> $stable(overrun_error) && $stable(framing_error) && $stable(parity_error))
    else $error("control write changed an error flag");

  chk_halt_rx: assert property (@(posedge clk_sys) disable iff (reset)
    rx_done && rx_halt && !low_power_entry |=> $stable(rx_buffer_r) && !$rose(rx_buffer_full))
    else $error("reception taken while halted");

  chk_stop2_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && !control_r.sync_mode && rx_frame.stop_first &&
    !low_power_entry |=> !framing_error)
    else $error("second stop bit raised framing error");

  // Odd count of ones, the odd-sense bit included, is a mismatch
  chk_parity_err: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && !control_r.sync_mode && control_r.parity_en &&
    (^{rx_frame.data, rx_frame.parity_bit, control_r.parity_odd}) && !low_power_entry
    |=> parity_error && !rx_buffer_full)
    else $error("parity mismatch not flagged");

  chk_frame_store: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && !rx_buffer_full && !control_r.sync_mode && !rx_frame.stop_first &&
    !low_power_entry |=> rx_buffer_r == $past(rx_frame.data))
    else $error("framing error did not store data");

  chk_mp_bit_to_send_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_status && !low_power_entry |=> mp_bit_to_send == $past(pwdata[ssf_pkg::SSF_B_MP_BIT_TO_SEND]))
    else $error("mp bit to send not written");

  chk_read_arms: assert property (@(posedge clk_sys) disable iff (reset)
    rd_status && !low_power_entry
    |=> &(armed_r | ~$past(prdata_r[7:ssf_pkg::SSF_FLAG_LO])))
    else $error("flag read as one not armed");

  chk_write_disarms: assert property (@(posedge clk_sys) disable iff (reset)
    wr_status |=> armed_r == '0)
    else $error("arm marks kept after status write");

  chk_sync_no_err: assert property (@(posedge clk_sys) disable iff (reset)
    rx_accept && control_r.sync_mode && !low_power_entry
    |=> !$rose(framing_error) && !$rose(parity_error))
    else $error("async-only error set in sync mode");

endmodule // ssf_status

// File: design/ssf_pkg.sv
/*
  Package for the serial status flag block: register map, field
  positions, reset values and the carrier structs.
  Assumes a 32-bit APB slave port and one 10 MHz system clock.
*/
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SSF_OFF_STATUS  = 8'h00;
  localparam logic [7:0] SSF_OFF_CONTROL = 8'h04;
  localparam logic [7:0] SSF_OFF_TXBUF   = 8'h08;
  localparam logic [7:0] SSF_OFF_RXBUF   = 8'h0C;
  localparam int         SSF_ADDR_W      = 8;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int SSF_B_TX_HOLDING_EMPTY = 7;
  localparam int SSF_B_RX_BUFFER_FULL = 6;
  localparam int SSF_B_OER  = 5;
  localparam int SSF_B_FER  = 4;
  localparam int SSF_B_PER  = 3;
  localparam int SSF_B_TX_DONE = 2;
  localparam int SSF_B_MP_BIT_RECEIVED = 1;
  localparam int SSF_B_MP_BIT_TO_SEND = 0;
  localparam int SSF_NFLAG  = 5;
  localparam int SSF_FLAG_LO = 3;

  localparam logic [7:0] SSF_STATUS_RST  = 8'h84;
  localparam logic [7:0] SSF_CONTROL_RST = 8'h00;
  localparam logic [7:0] SSF_BUF_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       two_stop;
    logic       mp_format;
    logic       parity_en;
    logic       parity_odd;
    logic       sync_mode;
    logic       rx_enable_bit;
    logic       tx_enable_bit;
    logic       spare;
  } ssf_control_s;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_bit;
    logic       stop_first;
    logic       stop_second;
    logic       mp_bit;
  } ssf_rx_frame_s;

endpackage

// File: verification/ssf_remote.sv
/*
  Far-side model: a remote party that sends received frames and takes
  characters out of the holding buffer.
  Assumes the one-cycle event pulses of ssf_status on clk_sys.
*/
`timescale 1ns/1ns
module ssf_remote #(
  parameter int CHAR_CYC = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              tx_stall,
  input  wire logic              tx_holding_valid,
  output logic                   tx_load = 1'b0,
  output logic                   tx_last_bit = 1'b0,
  output logic                   rx_done = 1'b0,
  output ssf_pkg::ssf_rx_frame_s rx_frame = '0
);
  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  int cnt_r;
  always_ff @(posedge clk_sys) begin
    tx_load     <= 1'b0;
    tx_last_bit <= 1'b0;
    if (reset) begin
      cnt_r <= 0;
    end else if (cnt_r != 0) begin
      cnt_r       <= cnt_r - 1;
      tx_last_bit <= (cnt_r == 1);
    end else if (tx_holding_valid && !tx_stall) begin
      tx_load <= 1'b1;
      cnt_r   <= CHAR_CYC;
    end
  end
  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  task automatic send(input ssf_pkg::ssf_rx_frame_s f);
    @(posedge clk_sys);
    rx_done  <= 1'b1;
    rx_frame <= f;
    @(posedge clk_sys);
    rx_done  <= 1'b0;
    rx_frame <= ~f;  // Stale frame must not look valid
  endtask
endmodule  // ssf_remote

// File: verification/test_serial_status_flags.sv
/*
  Self-checking bench for the serial status flags over APB.
  Assumes ssf_status and the ssf_remote far-side model.
*/
`timescale 1ns/1ns
module test_serial_status_flags;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ST = ssf_pkg::SSF_OFF_STATUS;
  localparam logic [7:0] CT = ssf_pkg::SSF_OFF_CONTROL;
  localparam logic [7:0] TB = ssf_pkg::SSF_OFF_TXBUF;
  localparam logic [7:0] RB = ssf_pkg::SSF_OFF_RXBUF;
  logic clk_sys = 1'b0, reset = 1'b1, low_power_entry = 1'b0, tx_stall = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, errv;
  logic [7:0] paddr = 8'h00, tx_holding_data;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, tx_load, tx_last_bit, rx_done, tx_holding_valid;
  logic mp_bit_to_send, rx_halt, tx_halt;
  ssf_pkg::ssf_rx_frame_s rx_frame;
  ssf_pkg::ssf_control_s serial_control;
  int failures = 0, compares = 0, cycles = 0;

  ssf_status ssf_status_i (.clk_sys, .reset, .low_power_entry, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_load, .tx_last_bit, .rx_done,
    .rx_frame, .tx_holding_data, .tx_holding_valid, .serial_control, .mp_bit_to_send,
    .rx_halt, .tx_halt);
  ssf_remote #(.CHAR_CYC(12)) ssf_remote_i (.clk_sys, .reset, .tx_stall, .tx_holding_valid,
    .tx_load, .tx_last_bit, .rx_done, .rx_frame);

  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin  // Far beyond the few hundred needed
      failures++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ends when pready is seen high; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rdv);
  endtask
  function automatic ssf_pkg::ssf_rx_frame_s fr(input logic [7:0] d, input logic p, s1, s2, m);
    return '{d, p, s1, s2, m};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("status", ST, 8'h84);
    rdchk("control", CT, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, errv});
    apb(1'b1, ST, 8'hFF);
    rdchk("status", ST, 8'h85);
    chk("mp out", 32'h1, {31'h0, mp_bit_to_send});
    apb(1'b1, ST, 8'h00);
    rdchk("status", ST, 8'h84);
  endtask
  task automatic t_rx();
    apb(1'b1, CT, 8'h04);
    ssf_remote_i.send(fr(8'hA5, 1'b0, 1'b1, 1'b1, 1'b0));
    rdchk("status", ST, 8'hC4);
    rdchk("rx buf", RB, 8'hA5);
    rdchk("status", ST, 8'h84);
  endtask
  task automatic t_overrun();
    apb(1'b1, ST, 8'h00);
    apb(1'b1, CT, 8'h0E);  // Sync mode so overrun also halts transmit
    ssf_remote_i.send(fr(8'h11, 1'b0, 1'b1, 1'b1, 1'b0));
    ssf_remote_i.send(fr(8'h22, 1'b0, 1'b1, 1'b1, 1'b0));
    apb(1'b1, TB, 8'h77);
    ssf_remote_i.send(fr(8'h33, 1'b0, 1'b1, 1'b1, 1'b0));
    @(negedge clk_sys);
    chk("rx halt", 32'h1, {31'h0, rx_halt});
    chk("tx halt", 32'h1, {31'h0, tx_halt});
    chk("tx valid", 32'h0, {31'h0, tx_holding_valid});
    apb(1'b1, ST, 8'h00);
    rdchk("status", ST, 8'h60);
    rdchk("rx buf", RB, 8'h11);
    apb(1'b1, ST, 8'h00);
    @(negedge clk_sys);
    chk("tx valid", 32'h1, {31'h0, tx_holding_valid});
    chk("tx data", 32'h77, {24'h0, tx_holding_data});
    apb(1'b1, CT, 8'h04);
    rdchk("status", ST, 8'h84);
  endtask
  task automatic t_framing();
    apb(1'b1, CT, 8'h84);
    ssf_remote_i.send(fr(8'h3C, 1'b0, 1'b1, 1'b0, 1'b0));
    rdchk("status", ST, 8'hC4);
    rdchk("rx buf", RB, 8'h3C);
    ssf_remote_i.send(fr(8'h5A, 1'b0, 1'b0, 1'b1, 1'b0));
    apb(1'b1, CT, 8'h00);
    ssf_remote_i.send(fr(8'h99, 1'b0, 1'b1, 1'b1, 1'b0));
    chk("rx halt", 32'h1, {31'h0, rx_halt});
    rdchk("rx buf", RB, 8'h5A);
    apb(1'b1, ST, 8'h00);
    rdchk("status", ST, 8'h94);
    apb(1'b1, ST, 8'h00);
    rdchk("status", ST, 8'h84);
  endtask
  task automatic t_parity();
    logic [7:0] c[4] = '{8'h24, 8'h24, 8'h34, 8'h34};
    logic [7:0] d[4] = '{8'h01, 8'h01, 8'h03, 8'h03};
    logic [7:0] e[4] = '{8'h8C, 8'hC4, 8'h8C, 8'hC4};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CT, c[i]);
      ssf_remote_i.send(fr(d[i], i[0], 1'b1, 1'b1, 1'b0));
      rdchk("status", ST, e[i]);
      rdchk("rx buf", RB, d[i]);
      apb(1'b1, ST, 8'h00);
    end
  endtask
  task automatic t_mp();
    apb(1'b1, CT, 8'h44);
    ssf_remote_i.send(fr(8'h10, 1'b0, 1'b1, 1'b1, 1'b1));
    rdchk("status", ST, 8'hC6);
    apb(1'b1, ST, 8'hC0);
    rdchk("status", ST, 8'hC6);
    rdchk("rx buf", RB, 8'h10);
  endtask
  task automatic t_tx();
    int n;
    apb(1'b1, CT, 8'h02);
    apb(1'b1, TB, 8'h3C);
    rdchk("status", ST, 8'h02);
    chk("tx data", 32'h3C, {24'h0, tx_holding_data});
    tx_stall <= 1'b0;
    for (n = 0; n < 50 && tx_load !== 1'b1; n++) @(negedge clk_sys);
    rdchk("status", ST, 8'h82);
    for (n = 0; n < 50 && tx_last_bit !== 1'b1; n++) @(negedge clk_sys);
    rdchk("status", ST, 8'h86);
    tx_stall <= 1'b1;
  endtask
  task automatic t_low_power();
    apb(1'b1, CT, 8'h04);
    ssf_remote_i.send(fr(8'h42, 1'b0, 1'b1, 1'b1, 1'b0));
    low_power_entry <= 1'b1;
    @(posedge clk_sys);
    low_power_entry <= 1'b0;
    rdchk("status", ST, 8'h84);
    rdchk("control", CT, 8'h04);
    chk("control out", 32'h04, {24'h0, serial_control});
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_rx();
    t_overrun();
    t_framing();
    t_parity();
    t_mp();
    t_tx();
    t_low_power();
    tally_and_finish();
  end
endmodule  // test_serial_status_flags
